// file: hdl/timer_pair_consts.svh
/*
  Constants for the capture/reload timer pair: register offsets, field
  positions, reset values and count limits.
  Assumes it is included by bare name, once per compilation unit.
*/
// What this block does
// - capture mode: extern, run, capture set, clock clear
// - event falling edge copies count into capture
// - capture mode flags overflow and capture events
// - first divider N gives clock over N+1
// - up mode: capture clear, run set, not up/down
// - first clock select picks event pin or divider
// - up count at all ones reloads, sets overflow
// - with extern and divided clock, event edge forces reload and event flag
// - up/down mode: event level picks direction
// - up reaching all ones reloads, toggles event flag
// - down reaching capture loads ones, toggles flag
// - direction enable only matters in reload modes
// - first run clear halts, keeps count
// - capture select and external enable fields
// - cascaded wrap to zero sets second overflow
// - gate enable lets external level gate divided counting
// - sixteen bit mode reloads low from high
// - reload select picks sixteen or cascaded mode
// - second clock select picks pin or divider
// - second run clear halts, keeps count
// - status flags clear on written zero only, except the event flag, which an up/down reload toggle also clears
// - event flag set on capture or event-edge reload
`ifndef TIMER_PAIR_CONSTS_SVH
`define TIMER_PAIR_CONSTS_SVH
`define OFF_T3       12'h000
`define OFF_T4       12'h004
`define OFF_CFG      12'h008
`define OFF_STAT     12'h00C
`define CFG_MASK     32'h01FFFFFF
`define STAT_MASK    32'h0000001F
`define REG_RESET    32'h00000000
`define B_T3_DIR     0
`define B_T3_EXT     1
`define B_T3_RUN     10
`define B_T3_CAP     11
`define B_T3_CLK     12
`define B_T4_RUN     21
`define B_T4_RL      22
`define B_T4_CLK     23
`define B_T4_GATE    24
`define F_T3_DIV_HI  9
`define F_T3_DIV_LO  2
`define F_T4_DIV_HI  20
`define F_T4_DIV_LO  13
`define B_EVENT_FLAG 4
`define B_FIRST_OVF  3
`define B_SECOND_OVF 2
`define B_TF_A       1
`define B_TF_B       0
`define ONES16       16'hFFFF
`define ONES32       32'hFFFFFFFF
`endif

// file: hdl/timer_pair_pkg.sv
/*
  Types for the capture/reload timer pair.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package timer_pair_pkg;
  typedef enum logic [1:0] {
    T3_STOP    = 2'b00,
    T3_CAPTURE = 2'b01,
    T3_UP      = 2'b10,
    T3_UPDOWN  = 2'b11
  } t3_mode_type;
endpackage
`default_nettype wire

// file: hdl/capture_reload_timer_pair.sv
/*
  Two timers behind an APB slave: a 16-bit capture/reload timer and a
  32-bit cascaded or 16-bit reload timer, plus their flag register.
  Assumes one 100 MHz clock, pins arriving asynchronously, zero-wait APB.
*/
`include "timer_pair_consts.svh"
`default_nettype none
module capture_reload_timer_pair
  import timer_pair_pkg::*;
(
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_b_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output var  logic [31:0] prdata_o,
  output var  logic        pready_o,
  output var  logic        pslverr_o,
  // external pins
  input  wire logic        first_timer_event_input_i,
  input  wire logic        second_timer_external_input_i,
  // match pulses from the simple timers
  input  wire logic        simple_timer_a_match_i,
  input  wire logic        simple_timer_b_match_i
);

  // register state
  logic [15:0] t3_count;
  logic [15:0] t3_capture;
  logic [15:0] second_timer_high_half;
  logic [15:0] second_timer_low_half;
  logic [31:0] cfg;
  logic        first_timer_event_flag;
  logic        first_timer_overflow_flag;
  logic        second_timer_overflow_flag;
  logic        simple_timer_a_match_flag;
  logic        simple_timer_b_match_flag;
  logic [7:0]  div3_cnt;
  logic [7:0]  div4_cnt;

  // pin synchronisers, bit 0 first timer, bit 1 second timer
  logic [1:0]  sync1;
  logic [1:0]  sync2;
  logic [1:0]  sync3;
  logic [1:0]  pin_level;

  // divider step: wraps after N, tick on the wrap cycle
  function automatic logic [7:0] next_div(input logic [7:0] cnt, input logic [7:0] n);
    next_div = (cnt >= n) ? 8'h00 : cnt + 8'h01;
  endfunction

  // configuration fields
  wire       first_timer_direction_enable = cfg[`B_T3_DIR];
  wire       first_timer_external_enable  = cfg[`B_T3_EXT];
  wire [7:0] first_timer_divider          = cfg[`F_T3_DIV_HI:`F_T3_DIV_LO];
  wire       first_timer_run              = cfg[`B_T3_RUN];
  wire       first_timer_capture_select   = cfg[`B_T3_CAP];
  wire       first_timer_clock_select     = cfg[`B_T3_CLK];
  wire [7:0] second_timer_divider         = cfg[`F_T4_DIV_HI:`F_T4_DIV_LO];
  wire       second_timer_run             = cfg[`B_T4_RUN];
  wire       second_timer_reload_select   = cfg[`B_T4_RL];
  wire       second_timer_clock_select    = cfg[`B_T4_CLK];
  wire       second_timer_gate_enable     = cfg[`B_T4_GATE];

  // apb decode; writes land only at the completing edge
  wire access   = psel_i & penable_i & pready_o;
  wire wr       = access & pwrite_i;
  wire sel_t3   = paddr_i == `OFF_T3;
  wire sel_t4   = paddr_i == `OFF_T4;
  wire sel_cfg  = paddr_i == `OFF_CFG;
  wire sel_stat = paddr_i == `OFF_STAT;
  wire mapped   = sel_t3 | sel_t4 | sel_cfg | sel_stat;
  wire wr_t3    = wr & sel_t3;
  wire wr_t4    = wr & sel_t4;
  wire wr_cfg   = wr & sel_cfg;
  wire wr_stat  = wr & sel_stat;

  // read data, reserved bits as zero
  wire [31:0] stat_word = {27'h0, first_timer_event_flag, first_timer_overflow_flag,
                           second_timer_overflow_flag, simple_timer_a_match_flag,
                           simple_timer_b_match_flag};
  wire [31:0] rd_data = sel_t3   ? {t3_count, t3_capture} :
                        sel_t4   ? {second_timer_high_half, second_timer_low_half} :
                        sel_cfg  ? cfg :
                        sel_stat ? stat_word : 32'h00000000;

  // filtered pin events: a change counts once stages two and three agree
  wire [1:0] pin_agree = ~(sync2 ^ sync3);
  wire [1:0] pin_fall  = pin_level & pin_agree & ~sync3;
  wire       ev_fall   = pin_fall[0];
  wire       ev_level  = pin_level[0];
  wire       ext_fall  = pin_fall[1];
  wire       ext_level = pin_level[1];

  // first timer mode decode; capture needs divided clock, reload needs capture clear
  wire capture_mode = first_timer_external_enable & first_timer_run &
                      first_timer_capture_select & ~first_timer_clock_select;
  wire updown_mode  = first_timer_run & ~first_timer_capture_select & first_timer_direction_enable &
                      first_timer_external_enable & ~first_timer_clock_select;
  wire up_mode      = first_timer_run & ~first_timer_capture_select & ~updown_mode;
  t3_mode_type t3_mode;
  assign t3_mode = capture_mode ? T3_CAPTURE : updown_mode ? T3_UPDOWN : up_mode ? T3_UP : T3_STOP;

  // count clocks
  wire div3_tick = div3_cnt >= first_timer_divider;
  wire div4_tick = div4_cnt >= second_timer_divider;
  wire t3_tick   = (first_timer_clock_select & ~capture_mode) ? ev_fall : div3_tick;
  wire gate_ok   = ~second_timer_gate_enable | ext_level;
  wire t4_tick   = second_timer_clock_select ? ext_fall : (div4_tick & gate_ok);

  // first timer hardware events
  wire t3_at_ones  = t3_count == `ONES16;
  wire t3_at_cap   = t3_count == t3_capture;
  wire ext_reload  = up_mode & first_timer_external_enable & ~first_timer_clock_select & ev_fall;
  wire up_reload   = up_mode & t3_tick & t3_at_ones;
  wire ud_up_rl    = updown_mode & t3_tick & ev_level & t3_at_ones;
  wire ud_down_rl  = updown_mode & t3_tick & ~ev_level & t3_at_cap;
  wire cap_wrap    = capture_mode & t3_tick & t3_at_ones;
  wire cap_event   = capture_mode & ev_fall;
  wire t3_ovf      = cap_wrap | up_reload | ud_up_rl | ud_down_rl;
  wire exf_set     = cap_event | ext_reload;
  wire exf_toggle  = ud_up_rl | ud_down_rl;

  // second timer hardware events
  wire [31:0] t4_pair   = {second_timer_high_half, second_timer_low_half};
  wire        t4_step   = second_timer_run & t4_tick;
  wire        t4_wrap32 = t4_step & ~second_timer_reload_select & (t4_pair == `ONES32);
  wire        t4_wrap16 = t4_step & second_timer_reload_select &
                          (second_timer_low_half == `ONES16);
  wire        t4_ovf    = t4_wrap32 | t4_wrap16;

  // status clears: a written zero clears, hardware set wins
  wire [4:0] clr = wr_stat ? ~pwdata_i[4:0] : 5'h00;

  // apb answer registers: zero-wait, answer in the access cycle
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      pready_o  <= 1'b0;
      prdata_o  <= `REG_RESET;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= psel_i & ~penable_i;
      prdata_o  <= rd_data;
      pslverr_o <= psel_i & ~penable_i & ~mapped;
    end
  end

  // three-stage pin synchronisers with agreement filter
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      sync1     <= 2'b11;
      sync2     <= 2'b11;
      sync3     <= 2'b11;
      pin_level <= 2'b11;
    end else begin
      sync1     <= {second_timer_external_input_i, first_timer_event_input_i};
      sync2     <= sync1;
      sync3     <= sync2;
      pin_level <= (pin_agree & sync3) | (~pin_agree & pin_level);
    end
  end

  // configuration and dividers; dividers free run so N+1 spacing holds
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      cfg      <= `REG_RESET;
      div3_cnt <= 8'h00;
      div4_cnt <= 8'h00;
    end else begin
      if (wr_cfg) begin
        cfg <= pwdata_i & `CFG_MASK;
      end
      div3_cnt <= next_div(div3_cnt, first_timer_divider);
      div4_cnt <= next_div(div4_cnt, second_timer_divider);
    end
  end

  // first timer counter and capture; a software write beats hardware
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      t3_count   <= 16'h0000;
      t3_capture <= 16'h0000;
    end else if (wr_t3) begin
      t3_count   <= pwdata_i[31:16];
      t3_capture <= pwdata_i[15:0];
    end else begin
      case (t3_mode)
        T3_CAPTURE: begin
          if (cap_event) begin
            t3_capture <= t3_count;
          end
          if (t3_tick) begin
            t3_count <= t3_count + 16'h0001;
          end
        end
        T3_UP: begin
          if (up_reload | ext_reload) begin
            t3_count <= t3_capture;
          end else if (t3_tick) begin
            t3_count <= t3_count + 16'h0001;
          end
        end
        T3_UPDOWN: begin
          if (ud_up_rl) begin
            t3_count <= t3_capture;
          end else if (ud_down_rl) begin
            t3_count <= `ONES16;
          end else if (t3_tick) begin
            t3_count <= ev_level ? t3_count + 16'h0001 : t3_count - 16'h0001;
          end
        end
        T3_STOP: begin
          t3_count <= t3_count;
        end
        default: begin
          t3_count <= t3_count;
        end
      endcase
    end
  end

  // second timer halves
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      second_timer_high_half <= 16'h0000;
      second_timer_low_half  <= 16'h0000;
    end else if (wr_t4) begin
      second_timer_high_half <= pwdata_i[31:16];
      second_timer_low_half  <= pwdata_i[15:0];
    end else if (t4_wrap16) begin
      second_timer_low_half <= second_timer_high_half;
    end else if (t4_step & second_timer_reload_select) begin
      second_timer_low_half <= second_timer_low_half + 16'h0001;
    end else if (t4_step) begin
      {second_timer_high_half, second_timer_low_half} <= t4_pair + 32'h00000001;
    end
  end

  // status flags: set or toggle wins over a software clear
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      first_timer_event_flag     <= 1'b0;
      first_timer_overflow_flag  <= 1'b0;
      second_timer_overflow_flag <= 1'b0;
      simple_timer_a_match_flag  <= 1'b0;
      simple_timer_b_match_flag  <= 1'b0;
    end else begin
      first_timer_event_flag     <= exf_toggle ? ~first_timer_event_flag :
                                    exf_set | (first_timer_event_flag & ~clr[`B_EVENT_FLAG]);
      first_timer_overflow_flag  <= t3_ovf | (first_timer_overflow_flag & ~clr[`B_FIRST_OVF]);
      second_timer_overflow_flag <= t4_ovf | (second_timer_overflow_flag & ~clr[`B_SECOND_OVF]);
      simple_timer_a_match_flag  <= simple_timer_a_match_i | (simple_timer_a_match_flag & ~clr[`B_TF_A]);
      simple_timer_b_match_flag  <= simple_timer_b_match_i | (simple_timer_b_match_flag & ~clr[`B_TF_B]);
    end
  end

  // checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);

  // a config write inside the window would move the divider, so none is allowed there
  sequence s_tick_then_steady;
    div3_tick && first_timer_divider == 8'h02 && !wr_cfg ##1 !wr_cfg ##1 !wr_cfg;
  endsequence

  sequence s_capture_hit;
    capture_mode && ev_fall && !wr_t3;
  endsequence

  property p_capture_copy;
    s_capture_hit |=> t3_capture == $past(t3_count);
  endproperty
  a_capture_copy: assert property (p_capture_copy) else $error("capture did not copy count");

  property p_capture_flag;
    s_capture_hit |=> first_timer_event_flag;
  endproperty
  a_capture_flag: assert property (p_capture_flag) else $error("capture flag not set");

  property p_divider_spacing;
    s_tick_then_steady |=> div3_tick && !$past(div3_tick) && !$past(div3_tick, 2);
  endproperty
  a_divider_spacing: assert property (p_divider_spacing) else $error("divider spacing wrong");

  property p_up_reload;
    up_mode && t3_tick && t3_at_ones && !wr_t3 |=> t3_count == $past(t3_capture) && first_timer_overflow_flag;
  endproperty
  a_up_reload: assert property (p_up_reload) else $error("up reload missing");

  property p_down_reload;
    updown_mode && t3_tick && !ev_level && t3_at_cap && !wr_t3 |=> t3_count == 16'hFFFF && $changed(first_timer_event_flag);
  endproperty
  a_down_reload: assert property (p_down_reload) else $error("down reload missing");

  property p_stop_holds;
    !first_timer_run && !wr_t3 && !wr_cfg [*2] |=> $stable(t3_count);
  endproperty
  a_stop_holds: assert property (p_stop_holds) else $error("stopped counter moved");

  property p_wrap32;
    t4_step && !second_timer_reload_select && t4_pair == 32'hFFFFFFFF && !wr_t4 |=> t4_pair == 32'h00000000 && second_timer_overflow_flag;
  endproperty
  a_wrap32: assert property (p_wrap32) else $error("cascade wrap wrong");

  property p_reload16;
    t4_wrap16 && !wr_t4 |=> second_timer_low_half == $past(second_timer_high_half) && second_timer_overflow_flag;
  endproperty
  a_reload16: assert property (p_reload16) else $error("16-bit reload wrong");

  property p_gate_blocks;
    second_timer_gate_enable && !ext_level && !second_timer_clock_select |-> !t4_tick;
  endproperty
  a_gate_blocks: assert property (p_gate_blocks) else $error("gate did not block");

  property p_zero_clears;
    wr_stat && !pwdata_i[`B_SECOND_OVF] && !t4_ovf |=> !second_timer_overflow_flag;
  endproperty
  a_zero_clears: assert property (p_zero_clears) else $error("flag not cleared");

  // per-mode behaviour; software writes are excluded since they beat hardware
  property p_capture_wrap;
    cap_wrap && !wr_t3 |=> t3_count == 16'h0000 && first_timer_overflow_flag;
  endproperty
  a_capture_wrap: assert property (p_capture_wrap) else $error("capture wrap wrong");

  property p_pin_reload;
    ext_reload && !wr_t3 |=> t3_count == $past(t3_capture) && first_timer_event_flag;
  endproperty
  a_pin_reload: assert property (p_pin_reload) else $error("pin reload missing");

  property p_up_toggle;
    ud_up_rl && !wr_t3 |=> t3_count == $past(t3_capture) && first_timer_overflow_flag &&
                           $changed(first_timer_event_flag);
  endproperty
  a_up_toggle: assert property (p_up_toggle) else $error("up reload in up/down wrong");

  property p_updown_step;
    updown_mode && t3_tick && !ud_up_rl && !ud_down_rl && !wr_t3 |=>
      t3_count == ($past(ev_level) ? $past(t3_count) + 16'h0001 : $past(t3_count) - 16'h0001);
  endproperty
  a_updown_step: assert property (p_updown_step) else $error("direction step wrong");

  property p_pin_clock_only;
    up_mode && first_timer_clock_select && !ev_fall && !wr_t3 |=> $stable(t3_count);
  endproperty
  a_pin_clock_only: assert property (p_pin_clock_only) else $error("counter moved without pin edge");

  property p_high_half_idle;
    t4_step && second_timer_reload_select && !wr_t4 |=> $stable(second_timer_high_half);
  endproperty
  a_high_half_idle: assert property (p_high_half_idle) else $error("high half moved in 16-bit mode");

  property p_cascade_carry;
    t4_step && !second_timer_reload_select && second_timer_low_half == 16'hFFFF && !wr_t4 |=>
      second_timer_low_half == 16'h0000 && second_timer_high_half == $past(second_timer_high_half) + 16'h0001;
  endproperty
  a_cascade_carry: assert property (p_cascade_carry) else $error("carry into high half wrong");

  property p_second_halt;
    !second_timer_run && !wr_t4 |=> $stable(t4_pair);
  endproperty
  a_second_halt: assert property (p_second_halt) else $error("stopped second timer moved");

  property p_pin_clock_second;
    second_timer_run && second_timer_clock_select && !ext_fall && !wr_t4 |=> $stable(t4_pair);
  endproperty
  a_pin_clock_second: assert property (p_pin_clock_second) else $error("second counter moved without edge");

  property p_one_ignored;
    wr_stat && pwdata_i[`B_TF_B] && simple_timer_b_match_flag |=> simple_timer_b_match_flag;
  endproperty
  a_one_ignored: assert property (p_one_ignored) else $error("written one cleared a flag");

endmodule
`default_nettype wire

// file: verif/ext_pins.sv
/*
  Far-side pin model: event pin, second timer pin and the two match pulses.
  Assumes the bench calls its tasks and that it shares clock_i with the design.
*/
`default_nettype none
module ext_pins (
  // clock
  input  wire logic clock_i,
  // pins towards the timers
  output var  logic ev_o,
  output var  logic ext_o,
  output var  logic ma_o,
  output var  logic mb_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // pins idle high so no false falling edge at reset release
  initial begin
    ev_o = 1'b1;
    ext_o = 1'b1;
    ma_o = 1'b0;
    mb_o = 1'b0;
  end

  // one pin level change, launched just after an edge
  task automatic level(input bit sel, input logic lvl);
    @(posedge clock_i);
    if (sel)
      ext_o <= lvl;
    else
      ev_o <= lvl;
  endtask

  // each level held four clocks so the input filter settles
  task automatic pulses(input bit sel, input int n);
    repeat (n) begin
      level(sel, 1'b0);
      repeat (3) @(posedge clock_i);
      level(sel, 1'b1);
      repeat (3) @(posedge clock_i);
    end
  endtask

  // one-cycle match pulse from a simple timer
  task automatic match(input bit sel);
    @(posedge clock_i);
    if (sel)
      mb_o <= 1'b1;
    else
      ma_o <= 1'b1;
    @(posedge clock_i);
    ma_o <= 1'b0;
    mb_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// file: verif/tb.sv
/*
  Self-checking bench for the timer pair: APB master, note queue, pin model.
  Assumes the design files and the pin model are compiled before it.
*/
`include "timer_pair_consts.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [31:0] d; logic [31:0] m; logic e;} note_type;
  localparam logic [31:0] run3 = 32'h1 << `B_T3_RUN;
  localparam logic [31:0] ext3 = 32'h1 << `B_T3_EXT;
  localparam logic [31:0] run4 = 32'h1 << `B_T4_RUN;
  logic        clock_i;
  logic        rst_b_i;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  wire logic   ev;
  wire logic   ext;
  wire logic   ma;
  wire logic   mb;
  note_type    q[$];
  int          n_fail = 0;
  int          num_checks = 0;
  // second timer cases: start value, config, expected count, overflow flag
  logic [31:0] t4_init [3] = '{32'h0001_FFF0, 32'hFFFF_FFF0, 32'h7000_FFF0};
  logic [31:0] t4_cfg  [3] = '{run4, run4, run4 | (32'h1 << `B_T4_RL)};
  logic [31:0] t4_exp  [3] = '{32'h0002_0000, 32'h0000_0000, 32'h7000_7000};
  logic [31:0] t4_flag [3] = '{32'h0, 32'h4, 32'h4};

  capture_reload_timer_pair dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .first_timer_event_input_i(ev), .second_timer_external_input_i(ext),
    .simple_timer_a_match_i(ma), .simple_timer_b_match_i(mb));
  ext_pins pins (.clock_i(clock_i), .ev_o(ev), .ext_o(ext), .ma_o(ma), .mb_o(mb));

  // free-running 100 MHz clock
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  task automatic miss(input string s);
    n_fail++;
    $display("Error %0t: %s", $time, s);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // only masked bits are compared, so free-running counts can be judged
  task automatic cmp_resp(input note_type nt, input logic [31:0] d, input logic e);
    num_checks++;
    if (((d & nt.m) !== (nt.d & nt.m)) || (e !== nt.e))
      miss($sformatf("apb answer %h/%b, wanted %h/%b mask %h", d, e, nt.d, nt.e, nt.m));
  endtask

  // one APB transfer; the next call waits an edge, so no double drive
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] e,
                      input logic [31:0] m, input logic err);
    int n;
    q.push_back('{e, m, err});
    @(posedge clock_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      miss("no pready");
      report_and_stop();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic err = 1'b0);
    xfer(1'b1, a, d, 32'h0, 32'h0, err);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m, input logic err = 1'b0);
    xfer(1'b0, a, 32'h0, e, m, err);
  endtask

  // run a config for n cycles, then stop both timers
  task automatic run(input logic [31:0] cfg, input int n);
    wr(`OFF_CFG, cfg);
    repeat (n) @(posedge clock_i);
    wr(`OFF_CFG, 32'h0);
  endtask

  // watcher: oldest note against each completed transfer
  always @(posedge clock_i) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      if (q.size() == 0)
        miss("answer without request");
      else
        cmp_resp(q.pop_front(), prdata, pslverr);
    end
  end

  // main sequence
  initial begin
    logic [31:0] r;
    rst_b_i = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    void'($urandom(65));
    repeat (6) @(posedge clock_i);
    rst_b_i <= 1'b1;
    for (int i = 0; i < 4; i++)
      rd(12'(4 * i), `REG_RESET, 32'hFFFF_FFFF);
    rd(12'h010, 32'h0, 32'hFFFF_FFFF, 1'b1);
    wr(12'h010, 32'hFFFF_FFFF, 1'b1);
    for (int i = 0; i < 3; i++) begin
      r = $urandom & ~(run3 | run4);
      wr(`OFF_CFG, r);
      rd(`OFF_CFG, r & `CFG_MASK, 32'hFFFF_FFFF);
      r = $urandom;
      wr(`OFF_CFG, 32'h0);
      wr(`OFF_T3, r);
      rd(`OFF_T3, r, 32'hFFFF_FFFF);
      wr(`OFF_T4, r);
      rd(`OFF_T4, r, 32'hFFFF_FFFF);
    end
    wr(`OFF_T3, 32'hFFF0_1000);
    wr(`OFF_STAT, 32'h0);
    run(run3, 40);
    rd(`OFF_T3, 32'h1000_1000, 32'hFF00_FFFF);
    rd(`OFF_STAT, 32'h08, 32'h08);
    wr(`OFF_T3, 32'h0000_8000);
    wr(`OFF_STAT, 32'h0);
    wr(`OFF_CFG, run3 | ext3);
    pins.pulses(1'b0, 1);
    wr(`OFF_CFG, 32'h0);
    rd(`OFF_T3, 32'h8000_8000, 32'hFF00_FFFF);
    rd(`OFF_STAT, 32'h10, 32'h18);
    wr(`OFF_T3, 32'h0);
    wr(`OFF_CFG, run3 | (32'h1 << `B_T3_CLK));
    pins.pulses(1'b0, 3);
    wr(`OFF_CFG, 32'h0);
    rd(`OFF_T3, 32'h0003_0000, 32'hFFFF_FFFF);
    wr(`OFF_T3, 32'hFFF0_0000);
    wr(`OFF_STAT, 32'h0);
    wr(`OFF_CFG, run3 | ext3 | (32'h1 << `B_T3_CAP) | 32'h1);
    repeat (528) @(posedge clock_i);
    pins.pulses(1'b0, 1);
    rd(`OFF_T3, 32'h0000_0200, 32'h0000_FF00);
    rd(`OFF_STAT, 32'h18, 32'h18);
    wr(`OFF_T3, 32'hFFF8_4000);
    wr(`OFF_STAT, 32'h0);
    wr(`OFF_CFG, run3 | ext3 | 32'h1);
    repeat (30) @(posedge clock_i);
    rd(`OFF_STAT, 32'h18, 32'h18);
    wr(`OFF_STAT, 32'h0);
    pins.level(1'b0, 1'b0);
    repeat (150) @(posedge clock_i);
    wr(`OFF_CFG, 32'h0);
    pins.level(1'b0, 1'b1);
    rd(`OFF_T3, 32'hFF00_4000, 32'hFF00_FFFF);
    rd(`OFF_STAT, 32'h18, 32'h18);
    wr(`OFF_T3, 32'h0);
    run(run3 | (32'h9 << 2), 300);
    rd(`OFF_T3, 32'h0010_0000, 32'hFFF0_0000);
    wr(`OFF_T3, 32'h0);
    run(run3 | (32'h2 << 2), 30);
    rd(`OFF_T3, 32'h000A_0000, 32'hFFFE_0000);
    for (int i = 0; i < 3; i++) begin
      wr(`OFF_T4, t4_init[i]);
      wr(`OFF_STAT, 32'h0);
      run(t4_cfg[i], 40);
      rd(`OFF_T4, t4_exp[i], 32'hFFFF_FF00);
      rd(`OFF_STAT, t4_flag[i], 32'h04);
    end
    wr(`OFF_T4, 32'h0);
    run(run4 | (32'h9 << 13), 300);
    rd(`OFF_T4, 32'h0000_0010, 32'hFFFF_FFF0);
    wr(`OFF_T4, 32'h0);
    pins.level(1'b1, 1'b0);
    // let the low level through the pin filter before the gate opens
    repeat (4) @(posedge clock_i);
    run(run4 | (32'h1 << `B_T4_GATE), 50);
    rd(`OFF_T4, 32'h0, 32'hFFFF_FFFF);
    pins.level(1'b1, 1'b1);
    run(run4 | (32'h1 << `B_T4_GATE), 50);
    rd(`OFF_T4, 32'h0000_0020, 32'hFFFF_FFE0);
    wr(`OFF_T4, 32'h0);
    wr(`OFF_CFG, run4 | (32'h1 << `B_T4_CLK));
    pins.pulses(1'b1, 5);
    wr(`OFF_CFG, 32'h0);
    rd(`OFF_T4, 32'h5, 32'hFFFF_FFFF);
    wr(`OFF_STAT, 32'h0);
    pins.match(1'b0);
    pins.match(1'b1);
    rd(`OFF_STAT, 32'h3, 32'hFFFF_FFFF);
    wr(`OFF_STAT, 32'hFFFF_FFFD);
    rd(`OFF_STAT, 32'h1, 32'hFFFF_FFFF);
    repeat (3) @(posedge clock_i);
    if (q.size() != 0)
      miss("requests left unanswered");
    report_and_stop();
  end
endmodule
`default_nettype wire
